/* src/pcs_pkg.sv */
package pcs_pkg;
  // serial frame: 1 read flag, 7 address bits, 8 data bits, msb first
  localparam int FRAME_BITS = 16;
  localparam int HDR_BITS = 8;
  localparam logic [4:0] CNT_HDR = 5'h08;
  localparam logic [4:0] CNT_FRAME = 5'h10;
  // register offsets
  localparam logic [6:0] ADDR_MEAS = 7'h08;
  localparam logic [6:0] ADDR_OPMODE = 7'h09;
  localparam logic [6:0] ADDR_COMP = 7'h0b;
  // measurement_result_control fields
  localparam int MEAS_CODE_LSB = 0;
  localparam int MEAS_SEL_LSB = 5;
  localparam int MEAS_GO_BIT = 7;
  // operating_mode_control fields
  localparam int OPM_MODE_LSB = 0;
  localparam int OPM_RSTFN_BIT = 2;
  localparam int OPM_SDLVL_BIT = 3;
  // asperity_compression_setup fields
  localparam int COMP_GATE_BIT = 0;
  localparam int COMP_TAU_BIT = 1;
  localparam int COMP_THR_LSB = 2;
  // measure_select codes
  localparam logic [1:0] SEL_LOW_SPAN = 2'h0;
  localparam logic [1:0] SEL_TEMP = 2'h3;
  // power-mode codes
  localparam logic [1:0] PM_SLEEP = 2'h0;
  localparam logic [1:0] PM_STANDBY = 2'h1;
  localparam logic [1:0] PM_ACTIVE = 2'h2;
  localparam logic [1:0] PM_TEST = 2'h3;
  // fault report filter
  localparam int FAULT_CLASSES = 6;
  localparam logic [2:0] FILT_NONE = 3'h0;
  localparam logic [2:0] FILT_ALL = 3'h7;
  // reset values
  localparam logic [7:0] MEAS_RST = 8'h00;
  localparam logic [7:0] OPMODE_RST = 8'h00;
  localparam logic [7:0] COMP_RST = 8'h00;
  localparam logic [3:0] FCODE_RST = 4'h0;

  typedef struct packed {
    logic sclk_q;
    logic sen_q;
    logic [4:0] cnt;
    logic [15:0] shift;
    logic [7:0] rdsh;
    logic sdo;
    logic sdoe;
    logic [7:0] meas;
    logic [4:0] result;
    logic [7:0] opmode;
    logic [7:0] comp;
    logic dig_start;
    logic [3:0] fcode;
    logic flt_seen;
    logic fault_pin;
    logic protect;
    logic meas_low;
    logic meas_high;
    logic meas_temp;
    logic dummy;
    logic [3:0] pm_onehot;
    logic bias_on;
    logic lf_raise;
    logic cap_boost;
    logic [1:0] swing;
    logic extra_comp;
    logic det_shift;
    logic sink;
    logic ms_flag;
  } pcs_state_t;
endpackage

/* src/pcs_regs.sv */
`timescale 1ns/1ns
`default_nettype none
// How it works
// - five-bit result is read-only in register
// - select code picks low, high span, temperature
// - digitize-go high requests a conversion
// - start on rise, clear result on fall
// - two-bit field picks sleep, standby, active, test
// - reset pin resets registers or selects dummy
// - gate bit lets fast pin steer passband
// - time-constant bit picks 700 or 70 ns
// - three-bit code picks compression threshold
// - test mode sinks fault line, flags multiples
// - fast pin switches reader bias during write
// - fast pin raises low corner to 8 MHz
// - boost bits add write boost and swing
// - write-current msb enables extra compensation
// - shift bit moves detector threshold span up
// - fault drives fault pin and latches code
// - pin follows fault, code stays latched
// - writing operating mode register clears code
// - masked faults still protect, no report
// - filter masks none, one class, or all
module pcs_regs
  import pcs_pkg::*;
(
  input wire logic CLK, // 25 MHz clock
  input wire logic RESET_N, // async reset, active low
  input wire logic SCLK, // serial clock
  input wire logic SEN, // serial enable, high in a frame
  input wire logic SDATA_IN, // serial data pin level
  output var logic SDATA_OUT, // serial data driven on read
  output var logic SDATA_OE, // high while driving serial data
  output var logic SDATA_5V, // read-back level select
  input wire logic ADC_DONE, // digitizer result valid pulse
  input wire logic [4:0] ADC_CODE, // digitizer raw code
  output var logic DIGITIZE_START, // one-cycle conversion start
  output var logic MEAS_LOW_SPAN, // low-span resistance chosen
  output var logic MEAS_HIGH_SPAN, // high-span resistance chosen
  output var logic MEAS_TEMP, // die temperature chosen
  input wire logic DUAL_USE_RESET_PIN, // dual-use reset pin
  output var logic DUMMY_HEAD_SEL, // dummy head in read
  output var logic POWER_SLEEP, // sleep mode
  output var logic POWER_STANDBY, // standby mode
  output var logic POWER_ACTIVE, // active or one-head servo write
  output var logic POWER_TEST, // test or two-head servo write
  input wire logic WRITE_MODE, // high in write mode
  input wire logic PASSBAND_FAST_PIN, // fast pin level
  input wire logic FAST_PIN_FUNCTION_SEL, // fast pin function
  input wire logic ASPERITY_COMPRESSION, // compression enabled
  output var logic READER_BIAS_ON, // reader bias generator on
  output var logic PASSBAND_LF_RAISE, // low corner to 8 MHz
  output var logic COMP_TIME_CONST_FAST, // 70 ns when high
  output var logic [2:0] COMPRESSION_THRESHOLD_CODE, // threshold
  input wire logic WRITE_CAP_BOOST, // capacitive boost bit
  input wire logic [1:0] WRITE_SWING_BOOST, // swing boost bits
  input wire logic WRITE_CURRENT_MSB, // write current msb
  output var logic CAP_BOOST_EN, // boost on transitions
  output var logic [1:0] SWING_BOOST_EN, // data swing increase
  output var logic EXTRA_COMP_EN, // extra driver compensation
  input wire logic DETECTOR_THRESHOLD_SHIFT, // shift bit
  output var logic DETECTOR_RANGE_HIGH, // detector span shifted
  input wire logic MULTI_SELECT_TEST_ENABLE, // test enable
  input wire logic DEVICE_SELECTED, // this device addressed
  input wire logic MULTIPLE_SELECT_DETECT, // fault line below ref
  output var logic FAULT_LINE_SINK, // sink test current
  output var logic MULTI_SELECT_FLAG, // more than one selected
  input wire logic [5:0] FAULT_EVENTS, // active fault classes
  input wire logic [2:0] FAULT_REPORT_FILTER, // report filter
  output var logic FAULT_PIN, // fault output pin level
  output var logic FAULT_PROTECT, // protective action request
  output var logic [3:0] LATCHED_FAULT_CODE // latched fault code
);
  // r is the registered state, n its next value
  pcs_state_t r, n;

  // read-back value of an address
  // unmapped addresses read as zero
  function automatic logic [7:0] rd_value(input pcs_state_t s,
                                          input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == ADDR_MEAS) begin
      v = {s.meas[7:5], s.result};
    end else if (a == ADDR_OPMODE) begin
      v = s.opmode;
    end else if (a == ADDR_COMP) begin
      v = s.comp;
    end
    return v;
  endfunction

  // next-state logic
  always_comb begin
    logic sclk_rise;
    logic sen_fall;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic commit;
    logic [5:0] unmasked;
    logic [3:0] code;
    logic unm_any;
    logic go_old;
    logic go_new;
    logic tac_gate;
    sclk_rise = 1'b0;
    sen_fall = 1'b0;
    addr = 7'h00;
    wdata = 8'h00;
    commit = 1'b0;
    unmasked = 6'h00;
    code = 4'h0;
    unm_any = 1'b0;
    go_old = 1'b0;
    go_new = 1'b0;
    tac_gate = 1'b0;
    n = r;
    n.sclk_q = SCLK;
    n.sen_q = SEN;
    n.dig_start = 1'b0;
    sclk_rise = SCLK && !r.sclk_q;
    sen_fall = r.sen_q && !SEN;
    addr = r.shift[FRAME_BITS-2:HDR_BITS];
    wdata = r.shift[HDR_BITS-1:0];

    // serial shifter
    // a cut frame never reaches a full count
    // rises beyond a full frame are ignored
    if (!SEN) begin
      n.cnt = 5'h00;
      n.sdoe = 1'b0;
    end else if (sclk_rise && r.cnt != CNT_FRAME) begin
      n.shift = {r.shift[FRAME_BITS-2:0], SDATA_IN};
      n.cnt = r.cnt + 5'h01;
      // read data leaves msb first, one bit per rise
      if (r.sdoe) begin
        n.sdo = r.rdsh[7];
        n.rdsh = {r.rdsh[6:0], 1'b0};
      end
      // header done: read frames turn the pin round
      if (r.cnt == CNT_HDR - 5'h01 && r.shift[HDR_BITS-2]) begin
        n.rdsh = rd_value(r, {r.shift[HDR_BITS-3:0], SDATA_IN});
        n.sdoe = 1'b1;
      end
    end

    // a read frame never commits
    // commit on frame end
    commit = sen_fall && r.cnt == CNT_FRAME && !r.shift[FRAME_BITS-1];
    // go bit before and after this commit
    go_old = r.meas[MEAS_GO_BIT];
    go_new = go_old;
    if (commit) begin
      if (addr == ADDR_MEAS) begin
        n.meas = {wdata[7:5], 5'h00};
        go_new = wdata[MEAS_GO_BIT];
      end else if (addr == ADDR_OPMODE) begin
        n.opmode = wdata;
      end else if (addr == ADDR_COMP) begin
        n.comp = wdata;
      end
    end

    if (go_new && !go_old) begin
      n.dig_start = 1'b1;
    end
    // result only loads while a conversion is asked for
    // result cleared on fall
    if (!go_new && go_old) begin
      n.result = 5'h00;
    end else if (ADC_DONE && go_old) begin
      n.result = ADC_CODE;
    end

    // class i is masked by filter code i+1
    // filter masks classes
    for (int i = 0; i < FAULT_CLASSES; i++) begin
      unmasked[i] = FAULT_EVENTS[i]
                    && FAULT_REPORT_FILTER != FILT_ALL
                    && FAULT_REPORT_FILTER != 3'(i + 1);
    end
    // lowest class wins when several rise together
    for (int i = FAULT_CLASSES - 1; i >= 0; i--) begin
      if (unmasked[i]) begin
        code = 4'(i + 1);
      end
    end
    unm_any = |unmasked;
    n.protect = |FAULT_EVENTS;
    // pin low in read, high in write
    n.fault_pin = WRITE_MODE ? unm_any : !unm_any;
    n.flt_seen = unm_any;
    // opmode write clears code, new fault wins
    if (commit && addr == ADDR_OPMODE) begin
      n.fcode = FCODE_RST;
    end
    // the code survives the fault going away
    // latch code on new fault
    if (unm_any && !r.flt_seen) begin
      n.fcode = code;
    end

    // a held pin keeps the registers clear each cycle
    // pin resets serial registers
    if (!r.opmode[OPM_RSTFN_BIT] && !DUAL_USE_RESET_PIN) begin
      n.meas = MEAS_RST;
      n.opmode = OPMODE_RST;
      n.comp = COMP_RST;
      n.result = 5'h00;
      n.fcode = FCODE_RST;
      n.dig_start = 1'b0;
    end
    n.dummy = r.opmode[OPM_RSTFN_BIT] && DUAL_USE_RESET_PIN;

    // decodes read the stored fields, one cycle behind
    // measurement decode
    n.meas_low = r.meas[MEAS_SEL_LSB+:2] == SEL_LOW_SPAN;
    n.meas_temp = r.meas[MEAS_SEL_LSB+:2] == SEL_TEMP;
    n.meas_high = !n.meas_low && !n.meas_temp;

    // exactly one power line is high
    // power mode decode
    n.pm_onehot = 4'h0;
    case (r.opmode[OPM_MODE_LSB+:2])
      PM_SLEEP: n.pm_onehot[0] = 1'b1;
      PM_STANDBY: n.pm_onehot[1] = 1'b1;
      PM_ACTIVE: n.pm_onehot[2] = 1'b1;
      default: n.pm_onehot[3] = 1'b1;
    endcase

    // reader bias off in write if fast pin high
    n.bias_on = !(WRITE_MODE && !FAST_PIN_FUNCTION_SEL
                  && PASSBAND_FAST_PIN);
    // bias stays on outside write or in passband use
    // gate matters while compression enabled
    tac_gate = !ASPERITY_COMPRESSION || r.comp[COMP_GATE_BIT];
    n.lf_raise = FAST_PIN_FUNCTION_SEL && PASSBAND_FAST_PIN && tac_gate;

    // settings from other registers pass one register
    // write boost bits
    n.cap_boost = WRITE_CAP_BOOST;
    n.swing = WRITE_SWING_BOOST;
    n.extra_comp = WRITE_CURRENT_MSB;
    n.det_shift = DETECTOR_THRESHOLD_SHIFT;
    n.sink = MULTI_SELECT_TEST_ENABLE && DEVICE_SELECTED;
    n.ms_flag = MULTI_SELECT_TEST_ENABLE && MULTIPLE_SELECT_DETECT;
  end

  // state register
  // reset leaves read-mode idle fault pin, sleep, low span
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r <= '{meas: MEAS_RST, opmode: OPMODE_RST, comp: COMP_RST,
             fcode: FCODE_RST, fault_pin: 1'b1, meas_low: 1'b1,
             pm_onehot: 4'h1, bias_on: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  // no output is combinational
  assign SDATA_OUT = r.sdo;
  assign SDATA_OE = r.sdoe;
  assign SDATA_5V = r.opmode[OPM_SDLVL_BIT];
  assign DIGITIZE_START = r.dig_start;
  assign MEAS_LOW_SPAN = r.meas_low;
  assign MEAS_HIGH_SPAN = r.meas_high;
  assign MEAS_TEMP = r.meas_temp;
  assign DUMMY_HEAD_SEL = r.dummy;
  assign POWER_SLEEP = r.pm_onehot[0];
  assign POWER_STANDBY = r.pm_onehot[1];
  assign POWER_ACTIVE = r.pm_onehot[2];
  assign POWER_TEST = r.pm_onehot[3];
  assign READER_BIAS_ON = r.bias_on;
  assign PASSBAND_LF_RAISE = r.lf_raise;
  // compression fields go out as stored
  // time-constant select
  assign COMP_TIME_CONST_FAST = r.comp[COMP_TAU_BIT];
  assign COMPRESSION_THRESHOLD_CODE = r.comp[COMP_THR_LSB+:3];
  assign CAP_BOOST_EN = r.cap_boost;
  assign SWING_BOOST_EN = r.swing;
  assign EXTRA_COMP_EN = r.extra_comp;
  assign DETECTOR_RANGE_HIGH = r.det_shift;
  assign FAULT_LINE_SINK = r.sink;
  assign MULTI_SELECT_FLAG = r.ms_flag;
  assign FAULT_PIN = r.fault_pin;
  assign FAULT_PROTECT = r.protect;
  assign LATCHED_FAULT_CODE = r.fcode;
endmodule
`default_nettype wire

/* tb/pcs_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pcs_host_model (
  input wire logic clk, // bench clock
  input wire logic sdo, // device read data
  output var logic sclk, // serial clock, still between frames
  output var logic sen, // frame enable
  output var logic sd // host data drive
);
  // idle levels at time zero
  initial begin
    sclk = 1'b0;
    sen = 1'b0;
    sd = 1'b0;
  end
  // nb bits of a frame msb first, fewer than 16 cut it short;
  // rd keeps the last 8 bits seen on the line
  task automatic xfer(input logic [15:0] f, input int nb,
                      output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk);
    sen <= 1'b1;
    for (int i = 15; i > 15 - nb; i--) begin
      sd <= f[i];
      repeat (2) @(posedge clk);
      sclk <= 1'b1;
      repeat (2) @(posedge clk);
      rd = {rd[6:0], sdo};
      sclk <= 1'b0;
    end
    @(posedge clk);
    sen <= 1'b0;
    // released line shows the inverse of the last bit
    sd <= ~f[16 - nb];
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* tb/pcs_regs_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module pcs_regs_asserts (
  input wire logic CLK, // clock
  input wire logic RESET_N, // async reset, active low
  input wire logic WRITE_MODE, // write mode
  input wire logic PASSBAND_FAST_PIN, // fast pin
  input wire logic FAST_PIN_FUNCTION_SEL, // fast pin function
  input wire logic READER_BIAS_ON, // reader bias
  input wire logic WRITE_CAP_BOOST, // boost bit
  input wire logic CAP_BOOST_EN, // boost enable
  input wire logic WRITE_CURRENT_MSB, // current msb
  input wire logic EXTRA_COMP_EN, // extra compensation
  input wire logic MULTI_SELECT_TEST_ENABLE, // test enable
  input wire logic DEVICE_SELECTED, // device addressed
  input wire logic FAULT_LINE_SINK, // sink current
  input wire logic [5:0] FAULT_EVENTS, // live faults
  input wire logic [2:0] FAULT_REPORT_FILTER, // filter
  input wire logic FAULT_PIN, // fault pin
  input wire logic FAULT_PROTECT, // protection
  input wire logic DIGITIZE_START, // start pulse
  input wire logic POWER_SLEEP, // sleep
  input wire logic POWER_STANDBY, // standby
  input wire logic POWER_ACTIVE, // active
  input wire logic POWER_TEST // test
);
  logic [5:0] unm;
  // fault classes that the filter lets through
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      unm[i] = FAULT_EVENTS[i] && FAULT_REPORT_FILTER != 3'h7 &&
        FAULT_REPORT_FILTER != 3'(i + 1);
    end
  end
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  // a start is a single cycle high
  sequence start_pulse;
    DIGITIZE_START ##1 !DIGITIZE_START;
  endsequence
  a_fault_pin_level:
    assert property (FAULT_PIN == $past(WRITE_MODE ? |unm : !(|unm)))
    else $error("fault pin level wrong");
  a_masked_protect:
    assert property (FAULT_PROTECT == $past(|FAULT_EVENTS))
    else $error("protection not taken");
  a_extra_comp_follow:
    assert property (EXTRA_COMP_EN == $past(WRITE_CURRENT_MSB))
    else $error("extra compensation wrong");
  a_cap_boost_follow:
    assert property (CAP_BOOST_EN == $past(WRITE_CAP_BOOST))
    else $error("cap boost wrong");
  a_bias_write_ctrl:
    assert property ($past(WRITE_MODE && !FAST_PIN_FUNCTION_SEL) |->
      READER_BIAS_ON == !$past(PASSBAND_FAST_PIN))
    else $error("reader bias wrong in write");
  a_sink_test_sel:
    assert property (FAULT_LINE_SINK ==
      $past(MULTI_SELECT_TEST_ENABLE && DEVICE_SELECTED))
    else $error("sink current wrong");
  a_start_one_pulse:
    assert property (DIGITIZE_START |-> start_pulse)
    else $error("start pulse too long");
  a_power_one_hot:
    assert property ($onehot({POWER_SLEEP, POWER_STANDBY, POWER_ACTIVE,
      POWER_TEST}))
    else $error("power mode not one-hot");
endmodule
`default_nettype wire

/* tb/pcs_regs_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
bind pcs_regs pcs_regs_asserts pcs_regs_asserts_i (.CLK(CLK),
  .RESET_N(RESET_N), .WRITE_MODE(WRITE_MODE),
  .PASSBAND_FAST_PIN(PASSBAND_FAST_PIN),
  .FAST_PIN_FUNCTION_SEL(FAST_PIN_FUNCTION_SEL),
  .READER_BIAS_ON(READER_BIAS_ON), .WRITE_CAP_BOOST(WRITE_CAP_BOOST),
  .CAP_BOOST_EN(CAP_BOOST_EN), .WRITE_CURRENT_MSB(WRITE_CURRENT_MSB),
  .EXTRA_COMP_EN(EXTRA_COMP_EN),
  .MULTI_SELECT_TEST_ENABLE(MULTI_SELECT_TEST_ENABLE),
  .DEVICE_SELECTED(DEVICE_SELECTED), .FAULT_LINE_SINK(FAULT_LINE_SINK),
  .FAULT_EVENTS(FAULT_EVENTS), .FAULT_REPORT_FILTER(FAULT_REPORT_FILTER),
  .FAULT_PIN(FAULT_PIN), .FAULT_PROTECT(FAULT_PROTECT),
  .DIGITIZE_START(DIGITIZE_START), .POWER_SLEEP(POWER_SLEEP),
  .POWER_STANDBY(POWER_STANDBY), .POWER_ACTIVE(POWER_ACTIVE),
  .POWER_TEST(POWER_TEST));
module pcs_regs_tb_top
  import pcs_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, done = 1'b0, dual_use_reset_pin = 1'b1, wm = 1'b0;
  logic fpin = 1'b0, fsel = 1'b0, asperity_compression = 1'b0, cb = 1'b0, imsb = 1'b0;
  logic dts = 1'b0, mst = 1'b0, dsel = 1'b0, mdet = 1'b0;
  logic [1:0] sw = 2'h0;
  logic [2:0] ff = 3'h0;
  logic [4:0] code = 5'h00;
  logic [5:0] fe = 6'h00;
  logic [7:0] x;
  int error_cnt = 0, checks = 0, starts = 0;
  wire logic sclk, sen, hsd, sdo, oe, st, dmy, fp, prot, lf, fast, drh, flg;
  wire logic [1:0] swe;
  wire logic [2:0] ms, thr;
  wire logic [3:0] pw, fc;
  wire logic v5;
  // pin level: device drives it while its enable is high
  wire logic sdi = oe ? sdo : hsd;
  always #20 clk = ~clk;
  // count conversion starts
  always @(posedge clk) if (st === 1'b1) starts++;
  pcs_host_model pcs_host_model_i (.clk(clk), .sdo(sdi), .sclk(sclk),
    .sen(sen), .sd(hsd));
  pcs_regs pcs_regs_i (.CLK(clk), .RESET_N(rst_n), .SCLK(sclk), .SEN(sen),
    .SDATA_IN(sdi), .SDATA_OUT(sdo), .SDATA_OE(oe), .SDATA_5V(v5),
    .ADC_DONE(done), .ADC_CODE(code), .DIGITIZE_START(st),
    .MEAS_LOW_SPAN(ms[0]), .MEAS_HIGH_SPAN(ms[1]), .MEAS_TEMP(ms[2]),
    .DUAL_USE_RESET_PIN(dual_use_reset_pin), .DUMMY_HEAD_SEL(dmy), .POWER_SLEEP(pw[0]),
    .POWER_STANDBY(pw[1]), .POWER_ACTIVE(pw[2]), .POWER_TEST(pw[3]),
    .WRITE_MODE(wm), .PASSBAND_FAST_PIN(fpin), .FAST_PIN_FUNCTION_SEL(fsel),
    .ASPERITY_COMPRESSION(asperity_compression), .READER_BIAS_ON(), .PASSBAND_LF_RAISE(lf),
    .COMP_TIME_CONST_FAST(fast), .COMPRESSION_THRESHOLD_CODE(thr),
    .WRITE_CAP_BOOST(cb), .WRITE_SWING_BOOST(sw), .WRITE_CURRENT_MSB(imsb),
    .CAP_BOOST_EN(), .SWING_BOOST_EN(swe), .EXTRA_COMP_EN(),
    .DETECTOR_THRESHOLD_SHIFT(dts), .DETECTOR_RANGE_HIGH(drh),
    .MULTI_SELECT_TEST_ENABLE(mst), .DEVICE_SELECTED(dsel),
    .MULTIPLE_SELECT_DETECT(mdet), .FAULT_LINE_SINK(),
    .MULTI_SELECT_FLAG(flg), .FAULT_EVENTS(fe), .FAULT_REPORT_FILTER(ff),
    .FAULT_PIN(fp), .FAULT_PROTECT(prot), .LATCHED_FAULT_CODE(fc));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] y;
    pcs_host_model_i.xfer({1'b0, a, d}, 16, y);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    pcs_host_model_i.xfer({1'b1, a, 8'h00}, 16, d);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({pw, 1'b0, ms}, 8'h11);
    rd(ADDR_COMP, x);
    chk(x, COMP_RST);
    wr(7'h0a, 8'hff);
    rd(7'h0a, x);
    chk(x, 8'h00);
    // a frame cut after 12 bits must not commit
    pcs_host_model_i.xfer({1'b0, ADDR_COMP, 8'hff}, 12, x);
    rd(ADDR_COMP, x);
    chk(x, COMP_RST);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_OPMODE, 8'(m) | 8'h04);
      chk({3'h0, dmy, pw}, 8'h10 | (8'h01 << m));
    end
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_MEAS, 8'(s << 5));
      chk({5'h0, ms}, s == 0 ? 8'h01 : s == 3 ? 8'h04 : 8'h02);
    end
    wr(ADDR_MEAS, 8'h80);
    chk(8'(starts), 8'h01);
    @(posedge clk);
    code <= 5'h15;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    wr(ADDR_MEAS, 8'h9f);
    rd(ADDR_MEAS, x);
    chk(x, 8'h95);
    chk(8'(starts), 8'h01);
    wr(ADDR_MEAS, 8'h00);
    rd(ADDR_MEAS, x);
    chk(x, 8'h00);
    for (int t = 0; t < 8; t++) begin
      wr(ADDR_COMP, 8'((t << 2) | ((t & 1) << 1)));
      chk({4'h0, fast, thr}, 8'((t & 1) << 3 | t));
    end
    asperity_compression <= 1'b1;
    fsel <= 1'b1;
    fpin <= 1'b1;
    wr(ADDR_COMP, 8'h00);
    chk({7'h0, lf}, 8'h00);
    wr(ADDR_COMP, 8'h01);
    chk({7'h0, lf}, 8'h01);
    fpin <= 1'b0;
    repeat (3) @(posedge clk);
    chk({7'h0, lf}, 8'h00);
    {fsel, wm, fpin, cb, sw, imsb, dts} <= 8'h7f;
    {mst, dsel, mdet} <= 3'h7;
    repeat (3) @(posedge clk);
    chk({swe, drh, flg}, 8'h0f);
    {wm, fe} <= 7'h04;
    repeat (3) @(posedge clk);
    chk({fp, 3'h0, fc}, 8'h03);
    fe <= 6'h00;
    repeat (3) @(posedge clk);
    chk({fp, 3'h0, fc}, 8'h83);
    wr(ADDR_OPMODE, 8'h0e);
    chk({fp, 3'h0, fc}, 8'h80);
    chk({7'h0, v5}, 8'h01);
    {ff, fe} <= 9'h041;
    repeat (3) @(posedge clk);
    chk({fp, prot, 2'h0, fc}, 8'hc0);
    {ff, fe} <= 9'h1ff;
    repeat (3) @(posedge clk);
    chk({fp, prot, 2'h0, fc}, 8'hc0);
    // each single-class filter code with every class active
    for (int k = 1; k < 7; k++) begin
      {ff, fe} <= {3'(k), 6'h00};
      wr(ADDR_OPMODE, 8'h06);
      fe <= 6'h3f;
      repeat (3) @(posedge clk);
      chk({4'h0, fc}, k == 1 ? 8'h02 : 8'h01);
    end
    wr(ADDR_OPMODE, 8'h02);
    dual_use_reset_pin <= 1'b0;
    repeat (3) @(posedge clk);
    chk({3'h0, dmy, pw}, 8'h01);
    finish_test();
  end
endmodule
`default_nettype wire
